// ### design/mme_monitor_entry.sv
`timescale 1ns/100ps
// How it works
// RULE_01: with both reset-vector bytes erased, monitor mode is entered without the test voltage.
// RULE_02: all monitor traffic uses the one host serial pin, driven open-drain with a pull-up.
// RULE_03: entry pins are sampled and the mode latched at reset release after a power-on reset.
// RULE_04: once latched, later changes on the entry-selection pins have no effect; in normal mode the two test-voltage pins still switch the watchdog.
// RULE_05: after reset in monitor mode the device waits for eight security bytes first.
// RULE_06: after the security bytes the device sends a break of ten zero bits as ready.
// RULE_07: normal entry needs 4.9152 MHz with divider select low or 9.8304 MHz with it high.
// RULE_08: forced-high entry needs an external clock of 9.8304 MHz.
// RULE_09: forced-low entry enables the PLL for a 32.768 kHz crystal.
// RULE_10: a serial bit lasts 256 bus clock cycles.
// RULE_11: the watchdog is off in forced mode, and in normal mode while the test voltage stays.
// RULE_12: a received break makes the device hold the line high two bits, then echo the break.
// RULE_13: a programmed vector without the test voltage gives user mode with the watchdog on.
// RULE_14: for normal entry the host holds serial pin high and select pins at fixed levels.
module mme_monitor_entry (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                porFlag,
	input  wire mme_pkg::mme_pins_s  entryPins,
	input  wire logic [7:0]          vectorHigh,
	input  wire logic [7:0]          vectorLow,
	input  wire logic                hostSerialIn,
	output logic                     hostSerialOut,
	output logic                     hostSerialOe,
	output logic                     monitorMode,
	output logic                     forcedMonitor,
	output logic                     pllEnable,
	output logic                     busDivideByFour,
	output logic                     watchdogEnable,
	output logic                     monitorReady,
	output logic [7:0]               hostByte,
	output logic                     securityByteValid,
	output logic                     commandByteValid
);
	mme_pkg::mme_pins_s  pinsMetaFf;
	mme_pkg::mme_pins_s  pinsFf;
	mme_pkg::mme_mode_e  modeFf;
	mme_pkg::mme_state_e stateFf;
	logic       serialMetaFf;
	logic       serialFf;
	logic       inResetFf;
	logic       porArmFf;
	logic       latchNow;
	logic       divideFf;
	logic [2:0] secCountFf;
	logic       txGoFf;
	logic       txLevelReqFf;
	logic [3:0] txBitsFf;
	logic       txDone;
	logic       rxEnable;
	logic       rxValid;
	logic [7:0] rxData;
	logic       rxBreak;
	logic       txBusy;
	logic       txLevelOut;

	function automatic logic vector_erased(input logic [7:0] hi, input logic [7:0] lo);
		return (hi == mme_pkg::ERASED_BYTE) && (lo == mme_pkg::ERASED_BYTE);
	endfunction

	function automatic mme_pkg::mme_mode_e pick_mode(input mme_pkg::mme_pins_s p,
			input logic erased);
		if (p.irqTestVoltage) begin
			return mme_pkg::MODE_NORMAL;
		end else if (erased && p.irqPinLevel) begin
			return mme_pkg::MODE_FORCED_HIGH; // RULE_08
		end else if (erased) begin
			return mme_pkg::MODE_FORCED_LOW; // RULE_09
		end else begin
			return mme_pkg::MODE_USER; // RULE_13
		end
	endfunction

	// pins arrive from outside, two stages before use
	always_ff @(posedge mclk) begin
		pinsMetaFf   <= entryPins;
		pinsFf       <= pinsMetaFf;
		serialMetaFf <= hostSerialIn;
		serialFf     <= serialMetaFf;
	end

	// the release edge only counts as entry when a power-on reset preceded it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			inResetFf <= 1'b1;
			if (porFlag) begin
				porArmFf <= 1'b1;
			end
		end else begin
			inResetFf <= 1'b0;
			porArmFf  <= 1'b0;
		end
	end

	assign latchNow = rst_n && inResetFf && porArmFf; // RULE_03

	// mode survives a plain reset: only power-on can leave a blank-vector monitor
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			if (porFlag) begin
				modeFf   <= mme_pkg::MODE_USER;
				divideFf <= 1'b0;
			end
		end else if (latchNow) begin
			modeFf   <= pick_mode(pinsFf, vector_erased(vectorHigh, vectorLow)); // RULE_01
			divideFf <= pinsFf.irqTestVoltage && pinsFf.dividerSelect; // RULE_07
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			monitorMode     <= 1'b0;
			forcedMonitor   <= 1'b0;
			pllEnable       <= 1'b0;
			busDivideByFour <= 1'b0;
			watchdogEnable  <= 1'b0;
		end else begin
			monitorMode     <= (modeFf != mme_pkg::MODE_USER); // RULE_04
			forcedMonitor   <= (modeFf == mme_pkg::MODE_FORCED_HIGH)
				|| (modeFf == mme_pkg::MODE_FORCED_LOW);
			pllEnable       <= (modeFf == mme_pkg::MODE_FORCED_LOW); // RULE_09
			busDivideByFour <= divideFf;
			case (modeFf)
				mme_pkg::MODE_USER: watchdogEnable <= 1'b1; // RULE_13
				mme_pkg::MODE_NORMAL: watchdogEnable <=
					!(pinsFf.irqTestVoltage || pinsFf.rstTestVoltage); // RULE_11
				default: watchdogEnable <= 1'b0; // RULE_11
			endcase
		end
	end

	assign txDone   = !txGoFf && !txBusy;
	// own transmissions echo back on the wired-OR line, so listening stops meanwhile
	assign rxEnable = txDone && ((stateFf == mme_pkg::ST_SECURE)
		|| (stateFf == mme_pkg::ST_READY));

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stateFf      <= mme_pkg::ST_IDLE;
			secCountFf   <= 3'h0;
			txGoFf       <= 1'b0;
			txLevelReqFf <= 1'b1;
			txBitsFf     <= 4'h0;
		end else begin
			txGoFf <= 1'b0;
			case (stateFf)
				mme_pkg::ST_IDLE: begin
					if (!inResetFf && modeFf != mme_pkg::MODE_USER) begin
						stateFf    <= mme_pkg::ST_SECURE; // RULE_05
						secCountFf <= 3'h0;
					end
				end
				mme_pkg::ST_SECURE: begin
					if (rxValid) begin
						secCountFf <= secCountFf + 3'h1; // RULE_05
						if (secCountFf == mme_pkg::SEC_LAST) begin
							stateFf      <= mme_pkg::ST_BREAK;
							txGoFf       <= 1'b1;
							txLevelReqFf <= 1'b0;
							txBitsFf     <= mme_pkg::BREAK_BITS; // RULE_06
						end
					end
				end
				mme_pkg::ST_BREAK: begin
					if (txDone) begin
						stateFf <= mme_pkg::ST_READY;
					end
				end
				mme_pkg::ST_READY: begin
					if (rxBreak) begin
						stateFf      <= mme_pkg::ST_HOLD;
						txGoFf       <= 1'b1;
						txLevelReqFf <= 1'b1;
						txBitsFf     <= mme_pkg::HOLD_BITS; // RULE_12
					end
				end
				mme_pkg::ST_HOLD: begin
					if (txDone) begin
						stateFf      <= mme_pkg::ST_ECHO;
						txGoFf       <= 1'b1;
						txLevelReqFf <= 1'b0;
						txBitsFf     <= mme_pkg::BREAK_BITS; // RULE_12
					end
				end
				mme_pkg::ST_ECHO: begin
					if (txDone) begin
						stateFf <= mme_pkg::ST_READY;
					end
				end
				default: stateFf <= mme_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hostSerialOut     <= 1'b0;
			hostSerialOe      <= 1'b0;
			monitorReady      <= 1'b0;
			hostByte          <= 8'h00;
			securityByteValid <= 1'b0;
			commandByteValid  <= 1'b0;
		end else begin
			// open drain: only a low is driven, the pull-up makes the high
			hostSerialOut     <= 1'b0; // RULE_02
			hostSerialOe      <= !txLevelOut; // RULE_02
			monitorReady      <= (stateFf == mme_pkg::ST_READY);
			securityByteValid <= rxValid && (stateFf == mme_pkg::ST_SECURE); // RULE_05
			commandByteValid  <= rxValid && (stateFf == mme_pkg::ST_READY);
			if (rxValid) begin
				hostByte <= rxData;
			end
		end
	end

	mme_serial_link link (
		.mclk       (mclk),
		.rst_n      (rst_n),
		.rxEnable   (rxEnable),
		.rxLine     (serialFf),
		.txStart    (txGoFf),
		.txLevel    (txLevelReqFf),
		.txBits     (txBitsFf),
		.rxValid    (rxValid),
		.rxData     (rxData),
		.rxBreak    (rxBreak),
		.txBusy     (txBusy),
		.txLevelOut (txLevelOut)
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence lastSecurityByte;
		stateFf == mme_pkg::ST_SECURE && rxValid && secCountFf == 3'h7;
	endsequence
	sequence breakRequested;
		txGoFf && !txLevelReqFf && txBitsFf == 4'hA ##1 txBusy && !txLevelOut;
	endsequence
	sequence breakHeard;
		stateFf == mme_pkg::ST_READY && rxBreak;
	endsequence
	sequence holdRequested;
		txGoFf && txLevelReqFf && txBitsFf == 4'h2;
	endsequence

	security_break_a: assert property (lastSecurityByte |=> breakRequested) // RULE_06
		else $error("no break after eighth security byte");
	break_echo_a: assert property (breakHeard |=> holdRequested) // RULE_12
		else $error("received break not answered with high hold");
	blank_entry_a: assert property ( // RULE_01
		latchNow && !pinsFf.irqTestVoltage && vectorHigh == 8'hFF && vectorLow == 8'hFF
		|=> modeFf != mme_pkg::MODE_USER)
		else $error("erased vector did not give monitor mode");
	mode_hold_a: assert property (!latchNow |=> $stable(modeFf)) // RULE_04
		else $error("mode changed without a power-on entry");
	user_watchdog_a: assert property ( // RULE_13
		modeFf == mme_pkg::MODE_USER ##1 modeFf == mme_pkg::MODE_USER |=> watchdogEnable)
		else $error("watchdog off in user mode");
	forced_watchdog_a: assert property ( // RULE_11
		(modeFf == mme_pkg::MODE_FORCED_HIGH || modeFf == mme_pkg::MODE_FORCED_LOW)
		|=> !watchdogEnable)
		else $error("watchdog on in forced monitor mode");
	secure_quiet_a: assert property ( // RULE_05
		stateFf == mme_pkg::ST_SECURE ##1 stateFf == mme_pkg::ST_SECURE |-> !hostSerialOe)
		else $error("device drove the line before security bytes");
	pll_forced_low_a: assert property ( // RULE_09
		modeFf == mme_pkg::MODE_FORCED_LOW |=> pllEnable)
		else $error("pll not enabled in forced low mode");
endmodule

// ### design/mme_pkg.sv
package mme_pkg;

	// serial timing in bus clock cycles (mclk is the bus clock)
	localparam int unsigned  BIT_CYCLES   = 256;
	localparam logic [7:0]   BIT_LAST     = 8'(BIT_CYCLES - 1);
	localparam logic [7:0]   HALF_LAST    = 8'(BIT_CYCLES / 2 - 1);
	localparam logic [3:0]   FRAME_LAST   = 4'h9;
	localparam logic [3:0]   BREAK_BITS   = 4'hA;
	localparam logic [3:0]   HOLD_BITS    = 4'h2;
	localparam logic [2:0]   SEC_LAST     = 3'h7;
	localparam logic [7:0]   ERASED_BYTE  = 8'hFF;

	typedef enum logic [3:0] {
		MODE_USER        = 4'h1,
		MODE_NORMAL      = 4'h2,
		MODE_FORCED_HIGH = 4'h4,
		MODE_FORCED_LOW  = 4'h8
	} mme_mode_e;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_SECURE = 6'h02,
		ST_BREAK  = 6'h04,
		ST_READY  = 6'h08,
		ST_HOLD   = 6'h10,
		ST_ECHO   = 6'h20
	} mme_state_e;

	typedef struct packed {
		logic irqTestVoltage;
		logic irqPinLevel;
		logic rstTestVoltage;
		logic dividerSelect;
	} mme_pins_s;

endpackage

// ### design/mme_serial_link.sv
`timescale 1ns/100ps
module mme_serial_link (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        rxEnable,
	input  wire logic        rxLine,
	input  wire logic        txStart,
	input  wire logic        txLevel,
	input  wire logic [3:0]  txBits,
	output logic             rxValid,
	output logic [7:0]       rxData,
	output logic             rxBreak,
	output logic             txBusy,
	output logic             txLevelOut
);
	logic       rxActiveFf;
	logic       rxLinePrevFf;
	logic [7:0] rxTimerFf;
	logic [3:0] rxCountFf;
	logic [8:0] rxShiftFf;
	logic [7:0] txTimerFf;
	logic [3:0] txLeftFf;

	assign txBusy = (txLeftFf != 4'h0);

	// sample mid-bit: half a bit after the start edge, then every bit period
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rxActiveFf   <= 1'b0;
			rxLinePrevFf <= 1'b1;
			rxTimerFf    <= 8'h00;
			rxCountFf    <= 4'h0;
			rxShiftFf    <= 9'h000;
			rxValid      <= 1'b0;
			rxBreak      <= 1'b0;
			rxData       <= 8'h00;
		end else begin
			rxValid      <= 1'b0;
			rxBreak      <= 1'b0;
			rxLinePrevFf <= rxLine;
			if (!rxActiveFf) begin
				// start is a falling edge: the tail of our own low is still in the synchroniser
				if (rxEnable && rxLinePrevFf && !rxLine) begin
					rxActiveFf <= 1'b1;
					rxTimerFf  <= mme_pkg::HALF_LAST; // RULE_10
					rxCountFf  <= 4'h0;
				end
			end else if (rxTimerFf == 8'h00) begin
				rxTimerFf <= mme_pkg::BIT_LAST; // RULE_10
				rxCountFf <= rxCountFf + 4'h1;
				if (rxCountFf == 4'h0) begin
					// glitch on the idle line, not a start bit
					if (rxLine) begin
						rxActiveFf <= 1'b0;
					end
				end else if (rxCountFf == mme_pkg::FRAME_LAST) begin
					rxActiveFf <= 1'b0;
					if (rxLine) begin
						rxValid <= 1'b1;
						rxData  <= rxShiftFf[8:1];
					end else if (rxShiftFf[8:1] == 8'h00) begin
						rxBreak <= 1'b1; // RULE_12
					end
				end else begin
					rxShiftFf <= {rxLine, rxShiftFf[8:1]};
				end
			end else begin
				rxTimerFf <= rxTimerFf - 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			txTimerFf  <= 8'h00;
			txLeftFf   <= 4'h0;
			txLevelOut <= 1'b1;
		end else if (txStart && !txBusy) begin
			txTimerFf  <= mme_pkg::BIT_LAST;
			txLeftFf   <= txBits;
			txLevelOut <= txLevel; // RULE_06
		end else if (txBusy) begin
			if (txTimerFf == 8'h00) begin
				txTimerFf <= mme_pkg::BIT_LAST; // RULE_10
				txLeftFf  <= txLeftFf - 4'h1;
				if (txLeftFf == 4'h1) begin
					txLevelOut <= 1'b1;
				end
			end else begin
				txTimerFf <= txTimerFf - 8'h01;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	rx_half_bit_a: assert property ( // RULE_10
		!rxActiveFf && rxEnable && rxLinePrevFf && !rxLine
		|=> rxActiveFf && rxTimerFf == mme_pkg::HALF_LAST)
		else $error("receiver did not wait half a bit");
	tx_load_a: assert property ( // RULE_06
		txStart && !txBusy |=> txBusy && txLevelOut == $past(txLevel) && txTimerFf == 8'hFF)
		else $error("transmitter did not load the request");
	tx_idle_high_a: assert property ( // RULE_02
		$fell(txBusy) |-> txLevelOut)
		else $error("line not released after transmit");
endmodule

// ### dv/mme_host_model.sv
`timescale 1ns/100ps
module mme_host_model (
	input  wire logic  mclk,
	output logic       hostOe
);
	initial hostOe = 1'b0;

	// bits go out LSB first; caller enters just after a rising edge
	task automatic send_bits(input logic [9:0] bits);
		for (int i = 0; i < 10; i++) begin
			hostOe = ~bits[i];
			repeat (mme_pkg::BIT_CYCLES) @(posedge mclk);
			#1;
		end
		if (hostOe) hostOe = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b);
		send_bits({1'b1, b, 1'b0});
	endtask

	// start plus nine zeros, then let the pull-up take the line
	task automatic send_break();
		send_bits(10'h000);
	endtask
endmodule

// ### dv/test_monitor_mode_entry.sv
`timescale 1ns/100ps
`define CHK(g, e) check(32'(g), 32'(e))
module test_monitor_mode_entry;
	logic                mclk;
	logic                rst_n;
	logic                porFlag;
	mme_pkg::mme_pins_s  entryPins;
	logic [7:0]          vectorHigh;
	logic [7:0]          vectorLow;
	wire logic           hostSerialIn;
	logic                hostSerialOut;
	logic                hostSerialOe;
	logic                monitorMode;
	logic                forcedMonitor;
	logic                pllEnable;
	logic                busDivideByFour;
	logic                watchdogEnable;
	logic                monitorReady;
	logic [7:0]          hostByte;
	logic                securityByteValid;
	logic                commandByteValid;
	logic                hostOe;
	wire logic [4:0]     modeBits;
	int                  fails;
	int                  tests_run;
	int                  cyc;
	int                  zeroRun;
	int                  lastZeros;
	int                  secCnt;
	int                  cmdCnt;
	int                  n;

	// wired-OR line with pull-up: low when either side pulls
	assign hostSerialIn = ~(hostOe | hostSerialOe);
	assign modeBits = {monitorMode, forcedMonitor, pllEnable, busDivideByFour, watchdogEnable};

	mme_host_model host_u (
		.mclk   (mclk),
		.hostOe (hostOe)
	);

	mme_monitor_entry dut_u (
		.mclk              (mclk),
		.rst_n             (rst_n),
		.porFlag           (porFlag),
		.entryPins         (entryPins),
		.vectorHigh        (vectorHigh),
		.vectorLow         (vectorLow),
		.hostSerialIn      (hostSerialIn),
		.hostSerialOut     (hostSerialOut),
		.hostSerialOe      (hostSerialOe),
		.monitorMode       (monitorMode),
		.forcedMonitor     (forcedMonitor),
		.pllEnable         (pllEnable),
		.busDivideByFour   (busDivideByFour),
		.watchdogEnable    (watchdogEnable),
		.monitorReady      (monitorReady),
		.hostByte          (hostByte),
		.securityByteValid (securityByteValid),
		.commandByteValid  (commandByteValid)
	);

	always #4 mclk = ~mclk;

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// counts zero-bit run lengths driven by the device, and pulses
	always @(posedge mclk) begin
		cyc++;
		if (securityByteValid === 1'b1) secCnt++;
		if (commandByteValid === 1'b1) cmdCnt++;
		if (hostSerialOe === 1'b1) begin
			zeroRun++;
		end else if (zeroRun != 0) begin
			lastZeros = zeroRun;
			zeroRun = 0;
		end
		if (cyc == 60000) begin
			fails++;
			stop_test();
		end
	end

	task automatic por_reset(input logic [3:0] pins, input logic [7:0] vh, input logic [7:0] vl,
			input logic por);
		rst_n = 1'b0;
		porFlag = por;
		entryPins = pins;
		vectorHigh = vh;
		vectorLow = vl;
		repeat (8) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
	endtask

	task automatic wait_oe(input logic lvl, input int lim, output int k);
		k = 0;
		while (hostSerialOe !== lvl && k < lim) begin
			@(posedge mclk);
			#1 k++;
		end
	endtask

	task automatic test_user();
		por_reset(4'h4, 8'h12, 8'hFF, 1'b1);
		`CHK(modeBits, 5'h01);
		host_u.send_byte(8'h3C);
		`CHK(secCnt, 0);
	endtask

	task automatic test_normal();
		for (int d = 0; d < 2; d++) begin
			// host leaves the serial pin released, i.e. high
			por_reset({3'h6, d[0]}, 8'hA5, 8'h5A, 1'b1);
			`CHK(modeBits, {3'h4, d[0], 1'b0});
			entryPins = 4'h2;
			repeat (4) @(posedge mclk);
			#1;
			`CHK(modeBits, {3'h4, d[0], 1'b0});
			entryPins = 4'h4;
			repeat (4) @(posedge mclk);
			#1;
			`CHK(modeBits, {3'h4, d[0], 1'b1});
		end
	endtask

	task automatic test_forced_low();
		por_reset(4'h0, 8'hFF, 8'hFF, 1'b1);
		`CHK(modeBits, 5'h1C);
		entryPins = 4'hF;
		repeat (4) @(posedge mclk);
		#1;
		`CHK(modeBits, 5'h1C);
		// a plain reset must not leave a blank-vector monitor
		por_reset(4'h4, 8'h12, 8'h34, 1'b0);
		`CHK(modeBits, 5'h1C);
	endtask

	task automatic test_forced_high();
		por_reset(4'h4, 8'hFF, 8'hFF, 1'b1);
		`CHK(modeBits, 5'h18);
		secCnt = 0;
		for (int i = 0; i < 7; i++) host_u.send_byte(8'h10 + 8'(i));
		`CHK({secCnt[3:0], hostByte, monitorReady, hostSerialOe}, 14'h1C58);
		host_u.send_byte(8'hE7);
		n = 0;
		while (monitorReady !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			#1 n++;
		end
		`CHK(lastZeros, 10 * mme_pkg::BIT_CYCLES);
		`CHK({secCnt[3:0], monitorReady}, 5'h11);
		host_u.send_byte(8'hC3);
		`CHK({cmdCnt[3:0], hostByte}, 12'h1C3);
		host_u.send_break();
		repeat (100) @(posedge mclk);
		#1;
		`CHK({hostSerialIn, hostSerialOe, hostSerialOut}, 3'h4);
		wait_oe(1'b1, 1000, n);
		`CHK((n + 100 >= 300) && (n + 100 <= 2 * mme_pkg::BIT_CYCLES), 1);
		lastZeros = 0;
		wait_oe(1'b0, 3000, n);
		repeat (4) @(posedge mclk);
		#1;
		`CHK(lastZeros, 10 * mme_pkg::BIT_CYCLES);
		`CHK(monitorReady, 1);
	endtask

	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		porFlag = 1'b1;
		entryPins = 4'h4;
		vectorHigh = 8'hFF;
		vectorLow = 8'hFF;
		fails = 0;
		tests_run = 0;
		cyc = 0;
		zeroRun = 0;
		lastZeros = 0;
		secCnt = 0;
		cmdCnt = 0;
		#1;
		test_user();
		test_normal();
		test_forced_low();
		test_forced_high();
		stop_test();
	end
endmodule
